// ### design/swl_write_lane_mask.sv
// Write port of a burst-of-four double-data-rate SRAM with lane write masking.
// Assumes edge pulses of both input clocks arrive synchronous to i_sys_clk and never together.
`timescale 1ns/1ps
module swl_write_lane_mask #(
	parameter int DATA_W = swl_pkg::DATA_W_DEF,
	parameter int ADDR_W = swl_pkg::ADDR_W_DEF
) (
	// Clock and reset
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_resetn,
	// Input clock rises
	input  wire logic                           i_kpos_rise,
	input  wire logic                           i_kneg_rise,
	// Write port
	input  wire logic                           i_write_port_select_n,
	input  wire logic [ADDR_W-1:0]              i_wr_burst_addr,
	input  wire logic [DATA_W-1:0]              i_wr_data,
	input  wire logic [swl_pkg::MAX_LANES-1:0]  i_lane_write_select_n,
	// Inspection port
	input  wire logic [ADDR_W+1:0]              i_rd_word_addr,
	output logic      [DATA_W-1:0]              o_rd_data,
	output logic                                o_burst_active
);
	import swl_pkg::*;

	localparam logic [MAX_LANES-1:0] USED = lanes_used(DATA_W);

	swl_state_type          state_q;
	logic                   pend_q;
	logic [ADDR_W-1:0]      pend_addr_q;
	logic [ADDR_W-1:0]      burst_addr_q;
	logic                   start_ok;
	logic                   wr_en;
	logic [BEAT_W-1:0]      wr_beat;
	logic [ADDR_W+1:0]      wr_addr;
	logic [DATA_W-1:0]      old_word;
	logic [DATA_W-1:0]      merged;
	logic [MAX_DATA_W-1:0]  sel_mask;
	logic                   all_off;
	logic [DATA_W-1:0]      mem_q [0:(1 << (ADDR_W + 2)) - 1];

	// ----------------------------------------------------------------
	// Burst start
	// ----------------------------------------------------------------
	// A start is refused while the previous positive rise already started one.
	assign start_ok = ~i_write_port_select_n & ~pend_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_q      <= PEND_RST;
			pend_addr_q <= '0;
		end else if (i_kpos_rise) begin
			pend_q <= start_ok;
			if (start_ok) begin
				pend_addr_q <= i_wr_burst_addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// Beat sequencing
	// ----------------------------------------------------------------
	// Beats land on positive, negative, positive, negative rises after the start.
	always_comb begin
		wr_en   = 1'b0;
		wr_beat = BEAT_FIRST;
		case (state_q)
			ST_IDLE: begin
				wr_en   = i_kpos_rise & pend_q;
				wr_beat = BEAT_FIRST;
			end
			ST_WAIT_B1: begin
				wr_en   = i_kneg_rise;
				wr_beat = BEAT_SECOND;
			end
			ST_WAIT_B2: begin
				wr_en   = i_kpos_rise;
				wr_beat = BEAT_THIRD;
			end
			ST_WAIT_B3: begin
				wr_en   = i_kneg_rise;
				wr_beat = BEAT_FOURTH;
			end
			default: begin
				wr_en   = 1'b0;
				wr_beat = BEAT_FIRST;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q        <= ST_IDLE;
			burst_addr_q   <= '0;
			o_burst_active <= ACTIVE_RST;
		end else if (wr_en) begin
			case (state_q)
				ST_IDLE: begin
					state_q        <= ST_WAIT_B1;
					burst_addr_q   <= pend_addr_q;
					o_burst_active <= 1'b1;
				end
				ST_WAIT_B1: begin
					state_q <= ST_WAIT_B2;
				end
				ST_WAIT_B2: begin
					state_q <= ST_WAIT_B3;
				end
				ST_WAIT_B3: begin
					state_q        <= ST_IDLE;
					o_burst_active <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Lane masked write
	// ----------------------------------------------------------------
	// The first beat uses the pending address directly, since the burst address is only loaded on it.
	assign wr_addr  = (state_q == ST_IDLE) ? {pend_addr_q, wr_beat} : {burst_addr_q, wr_beat};
	assign old_word = mem_q[wr_addr];
	assign sel_mask = lane_mask(DATA_W, i_lane_write_select_n);
	assign all_off  = ((~i_lane_write_select_n) & USED) == '0;

	swl_lane_merge #(
		.DATA_W (DATA_W)
	) u_merge (
		.i_old_word            (old_word),
		.i_new_word            (i_wr_data),
		.i_lane_write_select_n (i_lane_write_select_n),
		.o_merged_word         (merged)
	);

	// The array has no reset; its contents are undefined until written.
	always_ff @(posedge i_sys_clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= merged;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= mem_q[i_rd_word_addr];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// A start may ride on beat 2 of a running burst, so the state is left out of this check.
	chk_start_first_beat: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_kpos_rise && start_ok) |=> pend_q && pend_addr_q == $past(i_wr_burst_addr))
		else $error("accepted start did not arm the first beat");

	chk_refuse_repeat: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_kpos_rise && pend_q && !i_write_port_select_n) |=> !pend_q)
		else $error("start on consecutive positive rise was not ignored");

	chk_beat_sequence: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(state_q == ST_WAIT_B1 && i_kneg_rise) |-> wr_en && wr_beat == BEAT_SECOND
			##1 (state_q == ST_WAIT_B2 && o_burst_active))
		else $error("second beat not written on negative rise");

	chk_lane_written: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_en |-> ((merged ^ i_wr_data) & sel_mask[DATA_W-1:0]) == '0)
		else $error("selected lane not stored");

	// Case equality keeps words that were never written from tripping the checks on kept lanes.
	chk_lane_kept: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_en |-> (merged & ~sel_mask[DATA_W-1:0]) === (old_word & ~sel_mask[DATA_W-1:0]))
		else $error("unselected lane was altered");

	chk_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_en |=> mem_q[$past(wr_addr)] === $past(merged))
		else $error("merged word not stored at beat address");

	chk_all_low_full: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(wr_en && ((i_lane_write_select_n & USED) == '0)) |-> merged == i_wr_data)
		else $error("full word not stored with all selects low");

	chk_all_high_none: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(wr_en && all_off) |-> merged === old_word)
		else $error("memory changed with all selects high");

	if (DATA_W == NIBBLE_DATA_W) begin : g_nibble
		chk_low_nibble: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
			(wr_en && i_lane_write_select_n[1:0] == 2'h2) |-> merged === {old_word[7:4], i_wr_data[3:0]})
			else $error("low nibble write wrong");
		chk_high_nibble: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
			(wr_en && i_lane_write_select_n[1:0] == 2'h1) |-> merged === {i_wr_data[7:4], old_word[3:0]})
			else $error("high nibble write wrong");
	end

	if (DATA_W == 2 * BYTE_LANE_W) begin : g_two_lane
		chk_two_lane_map: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
			wr_en |-> merged[17:9] === (i_lane_write_select_n[1] ? old_word[17:9] : i_wr_data[17:9])
				&& merged[8:0] === (i_lane_write_select_n[0] ? old_word[8:0] : i_wr_data[8:0]))
			else $error("two lane mapping wrong");
	end

	if (DATA_W == BYTE_LANE_W) begin : g_one_lane
		chk_one_lane: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
			wr_en |-> merged === (i_lane_write_select_n[0] ? old_word : i_wr_data))
			else $error("single lane write wrong");
	end

endmodule : swl_write_lane_mask

// ### design/swl_pkg.sv
// Constants and helpers for the SRAM write-port lane masking block.
// Assumes the memory organisation is one of 8, 9, 18 or 36 data bits.
package swl_pkg;

	// ----------------------------------------------------------------
	// Organisation
	// ----------------------------------------------------------------
	localparam int DATA_W_DEF      = 36;
	localparam int ADDR_W_DEF      = 17;
	localparam int MAX_DATA_W      = 36;
	localparam int MAX_LANES       = 4;
	localparam int NIBBLE_LANE_W   = 4;
	localparam int BYTE_LANE_W     = 9;
	localparam int NIBBLE_DATA_W   = 8;
	localparam int BEAT_W          = 2;

	// ----------------------------------------------------------------
	// Burst beat positions and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] BEAT_FIRST  = 2'h0;
	localparam logic [1:0] BEAT_SECOND = 2'h1;
	localparam logic [1:0] BEAT_THIRD  = 2'h2;
	localparam logic [1:0] BEAT_FOURTH = 2'h3;
	localparam logic       PEND_RST    = 1'b0;
	localparam logic       ACTIVE_RST  = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_B1,
		ST_WAIT_B2,
		ST_WAIT_B3
	} swl_state_type;

	// Width of one lane for the given organisation.
	function automatic int lane_width(input int data_w);
		return (data_w == NIBBLE_DATA_W) ? NIBBLE_LANE_W : BYTE_LANE_W;
	endfunction : lane_width

	// Lane selects that exist in the given organisation.
	function automatic logic [MAX_LANES-1:0] lanes_used(input int data_w);
		logic [MAX_LANES-1:0] u;
		u = '0;
		for (int l = 0; l < MAX_LANES; l++) begin
			if (l < data_w / lane_width(data_w)) begin
				u[l] = 1'b1;
			end
		end
		return u;
	endfunction : lanes_used

	// Bit mask of the data bits whose lane select is low.
	function automatic logic [MAX_DATA_W-1:0] lane_mask(input int data_w, input logic [MAX_LANES-1:0] sel_n);
		logic [MAX_DATA_W-1:0] m;
		int lw;
		m  = '0;
		lw = lane_width(data_w);
		for (int i = 0; i < MAX_DATA_W; i++) begin
			if (i < data_w) begin
				m[i] = ~sel_n[2'(i / lw)];
			end
		end
		return m;
	endfunction : lane_mask

endpackage : swl_pkg

// ### design/swl_lane_merge.sv
// Merges one write beat into the stored word, lane by lane.
// Assumes lane selects are active low and already sampled on the beat's edge.
`timescale 1ns/1ps
module swl_lane_merge #(
	parameter int DATA_W = swl_pkg::DATA_W_DEF
) (
	// Words
	input  wire logic [DATA_W-1:0]              i_old_word,
	input  wire logic [DATA_W-1:0]              i_new_word,
	// Lane selects
	input  wire logic [swl_pkg::MAX_LANES-1:0]  i_lane_write_select_n,
	// Result
	output logic      [DATA_W-1:0]              o_merged_word
);
	import swl_pkg::*;

	logic [MAX_DATA_W-1:0] mask;

	// ----------------------------------------------------------------
	// Lane merge
	// ----------------------------------------------------------------
	always_comb begin
		mask          = lane_mask(DATA_W, i_lane_write_select_n);
		o_merged_word = (i_new_word & mask[DATA_W-1:0]) | (i_old_word & ~mask[DATA_W-1:0]);
	end

endmodule : swl_lane_merge

// ### verification/swl_ctrl_model.sv
// Memory controller model that drives the write port of the lane masking block.
// Assumes rise pulses are aligned to the system clock and driven 1 ns after its edge.
`timescale 1ns/1ps
module swl_ctrl_model #(
	parameter int DW = 36,
	parameter int AW = 4
) (
	// Clock
	input  wire logic           i_clk,
	// Write port
	output logic                o_kpos_rise,
	output logic                o_kneg_rise,
	output logic                o_write_port_select_n,
	output logic [AW-1:0]       o_burst_addr,
	output logic [DW-1:0]       o_data,
	output logic [3:0]          o_lane_write_select_n
);
	initial begin
		o_kpos_rise           = 1'b0;
		o_kneg_rise           = 1'b0;
		o_write_port_select_n = 1'b1;
		o_burst_addr          = '0;
		o_data                = '0;
		o_lane_write_select_n = 4'hF;
	end

	// ----------------------------------------------------------------
	// Burst
	// ----------------------------------------------------------------
	// Released lines show the inverse of their last value, so a stale sample never looks right.
	task automatic start(input logic [AW-1:0] a);
		@(posedge i_clk);
		#1;
		o_kpos_rise           = 1'b1;
		o_write_port_select_n = 1'b0;
		o_burst_addr          = a;
		@(posedge i_clk);
		#1;
		o_kpos_rise           = 1'b0;
		o_write_port_select_n = 1'b1;
		o_burst_addr          = ~a;
	endtask : start

	// Four beats on alternating rises; a further start to a2 rides on beat sb when sb is 0 to 3.
	task automatic beats(input logic [4*DW-1:0] d, input logic [15:0] s, input int gap,
			input logic [AW-1:0] a2, input int sb);
		for (int b = 0; b < 4; b++) begin
			repeat (gap) @(posedge i_clk);
			@(posedge i_clk);
			#1;
			o_kpos_rise           = (b % 2 == 0);
			o_kneg_rise           = (b % 2 == 1);
			o_data                = d[b*DW+:DW];
			o_lane_write_select_n = s[b*4+:4];
			if (b == sb) begin
				o_write_port_select_n = 1'b0;
				o_burst_addr          = a2;
			end
			@(posedge i_clk);
			#1;
			o_kpos_rise           = 1'b0;
			o_kneg_rise           = 1'b0;
			o_write_port_select_n = 1'b1;
			o_burst_addr          = ~o_burst_addr;
			o_data                = ~o_data;
			o_lane_write_select_n = ~o_lane_write_select_n;
		end
	endtask : beats
endmodule : swl_ctrl_model

// ### verification/swl_write_lane_mask_tb.sv
// Self-checking bench for the write lane masking block in its 36-bit organisation.
// Assumes the controller model above and the inspection read port of the block.
`timescale 1ns/1ps
module swl_write_lane_mask_tb;
	logic                  i_sys_clk;
	logic                  i_resetn;
	logic                  kpos, kneg, write_port_select_n;
	logic [3:0]            addr;
	logic [35:0]           data;
	logic [3:0]            sel_n;
	logic [5:0]            i_rd_word_addr;
	logic [35:0]           o_rd_data;
	logic                  o_burst_active;
	logic [35:0]           exp_mem [64];
	int                    n_mismatch = 0;
	int                    total_checks = 0;
	int                    act_cnt = 0;

	swl_write_lane_mask #(.DATA_W(36), .ADDR_W(4)) i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_kpos_rise(kpos), .i_kneg_rise(kneg), .i_write_port_select_n(write_port_select_n), .i_wr_burst_addr(addr),
		.i_wr_data(data), .i_lane_write_select_n(sel_n), .i_rd_word_addr(i_rd_word_addr),
		.o_rd_data(o_rd_data), .o_burst_active(o_burst_active));
	swl_ctrl_model #(.DW(36), .AW(4)) i_model (.i_clk(i_sys_clk), .o_kpos_rise(kpos), .o_kneg_rise(kneg),
		.o_write_port_select_n(write_port_select_n), .o_burst_addr(addr), .o_data(data),
		.o_lane_write_select_n(sel_n));

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// Counts settled high samples of the burst flag; each run compares the increase with three times the beat spacing.
	always @(negedge i_sys_clk) begin
		if (o_burst_active === 1'b1) begin
			act_cnt <= act_cnt + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Every lane differs from beat to beat, so a beat stored at the wrong word shows in any lane.
	function automatic logic [143:0] mk(input logic [7:0] k);
		logic [143:0] d;
		logic [7:0]   m;
		for (int b = 0; b < 4; b++) begin
			m           = 8'(b * 85);
			d[b*36+:36] = {k ^ m, 4'(b), k, ~k ^ m, k ^ m};
		end
		return d;
	endfunction : mk

	// Writes through the model, updates the expected array lane by lane, then reads back.
	// A chained burst sends no start of its own: its start rode on beat 2 of the burst before.
	task automatic run(input logic [3:0] a, input logic [143:0] d, input logic [15:0] s, input int gap,
			input logic [3:0] a2, input int sb, input bit chained);
		int act0;
		act0 = act_cnt;
		if (!chained) begin
			i_model.start(a);
		end
		i_model.beats(d, s, gap, a2, sb);
		for (int b = 0; b < 4; b++)
			for (int l = 0; l < 4; l++)
				if (!s[b*4+l]) exp_mem[{a, 2'(b)}][l*9+:9] = d[b*36+l*9+:9];
		check("burst_active", {35'h0, o_burst_active}, 36'h0);
		check("active_cycles", 36'(act_cnt - act0), 36'(3 * (gap + 2)));
		for (int b = 0; b < 4; b++) begin
			i_rd_word_addr = {a, 2'(b)};
			@(posedge i_sys_clk);
			@(posedge i_sys_clk);
			#1 check("rd_data", o_rd_data, exp_mem[{a, 2'(b)}]);
		end
	endtask : run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_full;
		run(4'h3, mk(8'hA5), 16'h0000, 0, 4'h0, -1, 1'b0);
		run(4'h5, mk(8'h3C), 16'h0000, 1, 4'h0, -1, 1'b0);
	endtask : t_full

	task automatic t_single_lanes;
		run(4'h3, mk(8'h96), 16'h7BDE, 2, 4'h0, -1, 1'b0);
	endtask : t_single_lanes

	task automatic t_mixed;
		run(4'h3, mk(8'h5A), 16'hCA5F, 0, 4'h0, -1, 1'b0);
	endtask : t_mixed

	task automatic t_double_start;
		run(4'h3, mk(8'hC3), 16'h0000, 0, 4'h5, 0, 1'b0);
		run(4'h5, mk(8'h0F), 16'hFFFF, 0, 4'h0, -1, 1'b0);
	endtask : t_double_start

	// The second start rides on beat 2, so its first beat follows the fourth beat of the first burst.
	task automatic t_chained;
		run(4'h6, mk(8'h24), 16'h0000, 0, 4'h5, 2, 1'b0);
		run(4'h5, mk(8'h81), 16'h1248, 1, 4'h0, -1, 1'b1);
	endtask : t_chained

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	initial begin
		#200000;
		n_mismatch++;
		results();
	end

	initial begin
		i_resetn = 1'b0;
		i_rd_word_addr = '0;
		repeat (8) @(posedge i_sys_clk);
		#1 i_resetn = 1'b1;
		check("idle_after_reset", {35'h0, o_burst_active}, 36'h0);
		t_full();
		t_single_lanes();
		t_mixed();
		t_double_start();
		t_chained();
		results();
	end
endmodule : swl_write_lane_mask_tb
